//--- flash_status_regs.vh
`ifndef FLASH_STATUS_REGS_VH
`define FLASH_STATUS_REGS_VH

// Register indices; byte address is four times the index
`define IDX_SECTOR_SELECT_STATUS_LOW 24'h080004
`define IDX_BANK_ERASE_STATUS_HIGH   24'h080006
`define IDX_PROGRAM_DATA0_LOW        24'h080008
`define IDX_PROGRAM_DATA0_HIGH       24'h08000a
`define IDX_PROGRAM_DATA1_LOW        24'h08000c
`define IDX_PROGRAM_DATA1_HIGH       24'h08000e
`define IDX_IRQ_STATUS               24'h080020
`define IDX_IRQ_MASK                 24'h080021
`define IDX_ERASE_VIEW               24'h080022

// Index to 32-bit byte address
`define BYTE_ADDR(i) ({6'h00, (i), 2'b00})

// Reset values
`define RST_STATUS_REG   16'h0000
`define RST_DATA_REG     16'hffff
`define RST_IRQ          3'h0
`define RST_SECTOR_BITS  8'h00
`define RST_BANK_BIT     1'b0

// Field positions
`define BANK_STATUS_POS  8
`define SECTOR_MSB       7
`define IRQ_END_OK       0
`define IRQ_END_ERR      1
`define IRQ_SUSPEND      2
`define IRQ_W            3

// Bus answers
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

//--- data_half_reg.v
`timescale 1ns/1ps
// One 16-bit software data register with byte lanes
module data_half_reg #(
    parameter [15:0] RST_VAL = 16'hffff
) (
    // Clock and reset
    input  wire        mclk_i,
    input  wire        rst_b_i,
    // Write port
    input  wire        we_i,
    input  wire [1:0]  strb_i,
    input  wire [15:0] wdata_i,
    // Stored value
    output wire [15:0] q_o
);
    reg  [15:0] val_ff;     // Stored value
    reg  [15:0] nxt_val;    // Next stored value

    // Merge only the strobed lanes; others keep their value
    always @* begin
        nxt_val = val_ff;
        if (we_i && strb_i[0]) begin
            nxt_val[7:0] = wdata_i[7:0];
        end
        if (we_i && strb_i[1]) begin
            nxt_val[15:8] = wdata_i[15:8];
        end
    end

    // Holds until rewritten or reset
    always @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            val_ff <= RST_VAL;
        end else begin
            val_ff <= nxt_val;
        end
    end

    assign q_o = val_ff;
endmodule // data_half_reg

//--- sticky_bits.v
`timescale 1ns/1ps
// Sticky event bits, cleared by writing one; a set beats a clear
module sticky_bits #(
    parameter W = 3
) (
    // Clock and reset
    input  wire         mclk_i,
    input  wire         rst_b_i,
    // Events and clear
    input  wire [W-1:0] set_i,
    input  wire [W-1:0] clr_i,
    // Sticky state
    output wire [W-1:0] q_o
);
    reg  [W-1:0] bits_ff;   // Sticky state

    // Set is ORed in after the clear so no event is lost
    always @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bits_ff <= {W{1'b0}};
        end else begin
            bits_ff <= (bits_ff & ~clr_i) | set_i;
        end
    end

    assign q_o = bits_ff;
endmodule // sticky_bits

//--- flash_erase_status_data_regs.v
`timescale 1ns/1ps
`include "flash_status_regs.vh"
module flash_erase_status_data_regs (
    // Clock and reset
    input  wire        mclk_i,
    input  wire        rst_b_i,
    // AXI4-Lite write address
    input  wire [31:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    // AXI4-Lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    // AXI4-Lite write response
    output wire [1:0]  s_axi_bresp,
    output wire        s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read address
    input  wire [31:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    // AXI4-Lite read data
    output wire [31:0] s_axi_rdata,
    output wire [1:0]  s_axi_rresp,
    output wire        s_axi_rvalid,
    input  wire        s_axi_rready,
    // Erase sequencer state
    input  wire        erase_run_i,
    input  wire        erase_end_i,
    input  wire        err_flag_i,
    input  wire        suspend_flag_i,
    input  wire [7:0]  sector_hit_i,
    input  wire [20:0] program_address_pair_i,
    // Toward the program/erase engine
    output wire [7:0]  sector_select_o,
    output wire [63:0] program_data_o,
    output wire [20:0] program_address_o,
    // Status meaning
    output wire        bank_status_bit_o,
    output wire        bank_erase_failed_o,
    output wire        bank_erase_suspended_o,
    output wire [7:0]  sector_failed_o,
    output wire [7:0]  sector_suspended_o,
    // Interrupt
    output wire        irq_o
);
    // Write channel holding state
    reg         aw_full_ff;     // Write address captured
    reg         w_full_ff;      // Write data captured
    reg  [31:0] awaddr_ff;      // Captured write address
    reg  [31:0] wdata_ff;       // Captured write data
    reg  [3:0]  wstrb_ff;       // Captured byte strobes
    reg         bvalid_ff;      // Response pending
    reg  [1:0]  bresp_ff;       // Response code
    // Read channel state
    reg         rvalid_ff;      // Read data pending
    reg  [31:0] rdata_ff;       // Read data
    reg  [1:0]  rresp_ff;       // Read response code
    // Erase status state
    reg  [7:0]  sector_bits_ff; // Sector select / status
    reg         bank_bit_ff;    // Bank status bit
    reg  [7:0]  nxt_sector_bits;
    reg         nxt_bank_bit;
    reg         suspend_flag_d_ff;      // Suspend flag one cycle ago
    reg  [2:0]  irq_mask_ff;    // Interrupt enables
    // Combinational decode
    reg  [31:0] rd_mux;         // Read data mux
    reg         rd_hit;         // Read address mapped
    reg         wr_hit;         // Write address mapped
    wire        wr_go;          // Write performed this cycle
    wire        rd_go;          // Read accepted this cycle
    wire [15:0] data0_lo;       // Data register outputs
    wire [15:0] data0_hi;
    wire [15:0] data1_lo;
    wire [15:0] data1_hi;
    wire [2:0]  irq_status;     // Sticky event bits
    wire [2:0]  irq_set;        // Event pulses
    wire [2:0]  irq_clr;        // Write-one-to-clear
    wire        end_ok;         // Erase ended cleanly
    wire        end_err;        // Erase ended with error
    wire        we_sel;         // Write strobes per register
    wire        we_bank;
    wire        we_d0l;
    wire        we_d0h;
    wire        we_d1l;
    wire        we_d1h;
    wire        we_isr;
    wire        we_imask;

    // A write happens once both halves are in and the last answer left
    assign wr_go = aw_full_ff & w_full_ff & ~bvalid_ff;
    assign rd_go = s_axi_arvalid & ~rvalid_ff;

    // Ready only while the holding slot is empty
    assign s_axi_awready = ~aw_full_ff & ~bvalid_ff;
    assign s_axi_wready  = ~w_full_ff & ~bvalid_ff;
    assign s_axi_arready = ~rvalid_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;

    // Write address decode
    always @* begin
        case (awaddr_ff)
            `BYTE_ADDR(`IDX_SECTOR_SELECT_STATUS_LOW),
            `BYTE_ADDR(`IDX_BANK_ERASE_STATUS_HIGH),
            `BYTE_ADDR(`IDX_PROGRAM_DATA0_LOW),
            `BYTE_ADDR(`IDX_PROGRAM_DATA0_HIGH),
            `BYTE_ADDR(`IDX_PROGRAM_DATA1_LOW),
            `BYTE_ADDR(`IDX_PROGRAM_DATA1_HIGH),
            `BYTE_ADDR(`IDX_IRQ_STATUS),
            `BYTE_ADDR(`IDX_IRQ_MASK),
            `BYTE_ADDR(`IDX_ERASE_VIEW): wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    assign we_sel   = wr_go && (awaddr_ff == `BYTE_ADDR(`IDX_SECTOR_SELECT_STATUS_LOW));
    assign we_bank  = wr_go && (awaddr_ff == `BYTE_ADDR(`IDX_BANK_ERASE_STATUS_HIGH));
    assign we_d0l   = wr_go && (awaddr_ff == `BYTE_ADDR(`IDX_PROGRAM_DATA0_LOW));
    assign we_d0h   = wr_go && (awaddr_ff == `BYTE_ADDR(`IDX_PROGRAM_DATA0_HIGH));
    assign we_d1l   = wr_go && (awaddr_ff == `BYTE_ADDR(`IDX_PROGRAM_DATA1_LOW));
    assign we_d1h   = wr_go && (awaddr_ff == `BYTE_ADDR(`IDX_PROGRAM_DATA1_HIGH));
    assign we_isr   = wr_go && (awaddr_ff == `BYTE_ADDR(`IDX_IRQ_STATUS));
    assign we_imask = wr_go && (awaddr_ff == `BYTE_ADDR(`IDX_IRQ_MASK));

    // Write channel: take address and data in either order
    always @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            aw_full_ff <= 1'b0;
            w_full_ff  <= 1'b0;
            awaddr_ff  <= 32'h00000000;
            wdata_ff   <= 32'h00000000;
            wstrb_ff   <= 4'h0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= `RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_ff <= 1'b1;
                awaddr_ff  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_ff <= 1'b1;
                wdata_ff  <= s_axi_wdata;
                wstrb_ff  <= s_axi_wstrb;
            end
            if (wr_go) begin
                // Unmapped writes are dropped and answered with an error
                aw_full_ff <= 1'b0;
                w_full_ff  <= 1'b0;
                bvalid_ff  <= 1'b1;
                bresp_ff   <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // Program data registers, 16 bits each in the low lanes
    data_half_reg #(.RST_VAL(`RST_DATA_REG)) u_data0_lo (
        .mclk_i  (mclk_i),
        .rst_b_i (rst_b_i),
        .we_i    (we_d0l),
        .strb_i  (wstrb_ff[1:0]),
        .wdata_i (wdata_ff[15:0]),
        .q_o     (data0_lo)
    );
    data_half_reg #(.RST_VAL(`RST_DATA_REG)) u_data0_hi (
        .mclk_i  (mclk_i),
        .rst_b_i (rst_b_i),
        .we_i    (we_d0h),
        .strb_i  (wstrb_ff[1:0]),
        .wdata_i (wdata_ff[15:0]),
        .q_o     (data0_hi)
    );
    data_half_reg #(.RST_VAL(`RST_DATA_REG)) u_data1_lo (
        .mclk_i  (mclk_i),
        .rst_b_i (rst_b_i),
        .we_i    (we_d1l),
        .strb_i  (wstrb_ff[1:0]),
        .wdata_i (wdata_ff[15:0]),
        .q_o     (data1_lo)
    );
    data_half_reg #(.RST_VAL(`RST_DATA_REG)) u_data1_hi (
        .mclk_i  (mclk_i),
        .rst_b_i (rst_b_i),
        .we_i    (we_d1h),
        .strb_i  (wstrb_ff[1:0]),
        .wdata_i (wdata_ff[15:0]),
        .q_o     (data1_hi)
    );

    // Odd word in the upper half, even word in the lower half
    assign program_data_o    = {data1_hi, data1_lo, data0_hi, data0_lo};
    assign program_address_o = program_address_pair_i;

    assign end_ok  = erase_end_i & ~err_flag_i;
    assign end_err = erase_end_i & err_flag_i;

    // Erase status next state: clean end clears, software writes,
    // and the hardware set is applied last so it wins over a clear
    always @* begin
        nxt_sector_bits = sector_bits_ff;
        nxt_bank_bit    = bank_bit_ff;
        if (end_ok) begin
            nxt_sector_bits = 8'h00;
            nxt_bank_bit    = 1'b0;
        end
        if (we_sel && wstrb_ff[0]) begin
            nxt_sector_bits = wdata_ff[`SECTOR_MSB:0];
        end
        if (we_bank && wstrb_ff[1]) begin
            nxt_bank_bit = wdata_ff[`BANK_STATUS_POS];
        end
        if (erase_run_i) begin
            // Sectors under erase report their state
            nxt_sector_bits = nxt_sector_bits | sector_hit_i;
            nxt_bank_bit    = 1'b1;
        end
    end

    // Erase status registers
    always @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            // Sector field is only eight bits wide, so its own reset constant
            sector_bits_ff <= `RST_SECTOR_BITS;
            bank_bit_ff    <= `RST_BANK_BIT;
            suspend_flag_d_ff      <= 1'b0;
            irq_mask_ff    <= `RST_IRQ;
        end else begin
            sector_bits_ff <= nxt_sector_bits;
            bank_bit_ff    <= nxt_bank_bit;
            suspend_flag_d_ff      <= suspend_flag_i;
            if (we_imask && wstrb_ff[0]) begin
                irq_mask_ff <= wdata_ff[`IRQ_W-1:0];
            end
        end
    end

    assign sector_select_o   = sector_bits_ff;
    assign bank_status_bit_o = bank_bit_ff;

    // Error overrides suspend; with neither flag the bits mean nothing
    assign bank_erase_failed_o    = bank_bit_ff & err_flag_i;
    assign sector_failed_o        = sector_bits_ff & {8{err_flag_i}};
    assign bank_erase_suspended_o = bank_bit_ff & ~err_flag_i & suspend_flag_i;
    assign sector_suspended_o     = sector_bits_ff & {8{~err_flag_i & suspend_flag_i}};

    // Interrupt events: clean end, failed end, suspend entry
    assign irq_set[`IRQ_END_OK]  = end_ok;
    assign irq_set[`IRQ_END_ERR] = end_err;
    assign irq_set[`IRQ_SUSPEND] = suspend_flag_i & ~suspend_flag_d_ff;
    assign irq_clr = (we_isr && wstrb_ff[0]) ? wdata_ff[`IRQ_W-1:0] : 3'h0;

    sticky_bits #(.W(`IRQ_W)) u_irq_status (
        .mclk_i  (mclk_i),
        .rst_b_i (rst_b_i),
        .set_i   (irq_set),
        .clr_i   (irq_clr),
        .q_o     (irq_status)
    );

    // Level interrupt while any enabled event is pending
    assign irq_o = |(irq_status & irq_mask_ff);

    // Read mux; reserved bits read as zero
    always @* begin
        rd_hit = 1'b1;
        rd_mux = 32'h00000000;
        case (s_axi_araddr)
            `BYTE_ADDR(`IDX_SECTOR_SELECT_STATUS_LOW): rd_mux[7:0] = sector_bits_ff;
            `BYTE_ADDR(`IDX_BANK_ERASE_STATUS_HIGH):
                rd_mux[`BANK_STATUS_POS] = bank_bit_ff;
            `BYTE_ADDR(`IDX_PROGRAM_DATA0_LOW):  rd_mux[15:0] = data0_lo;
            `BYTE_ADDR(`IDX_PROGRAM_DATA0_HIGH): rd_mux[15:0] = data0_hi;
            `BYTE_ADDR(`IDX_PROGRAM_DATA1_LOW):  rd_mux[15:0] = data1_lo;
            `BYTE_ADDR(`IDX_PROGRAM_DATA1_HIGH): rd_mux[15:0] = data1_hi;
            `BYTE_ADDR(`IDX_IRQ_STATUS): rd_mux[2:0] = irq_status;
            `BYTE_ADDR(`IDX_IRQ_MASK):   rd_mux[2:0] = irq_mask_ff;
            `BYTE_ADDR(`IDX_ERASE_VIEW):
                rd_mux[3:0] = {suspend_flag_i, err_flag_i, erase_end_i, erase_run_i};
            default: rd_hit = 1'b0;
        endcase
    end

    // Read channel: data registered one cycle after the address
    always @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h00000000;
            rresp_ff  <= `RESP_OKAY;
        end else if (rd_go) begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= rd_mux;
            rresp_ff  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end
endmodule // flash_erase_status_data_regs

//--- erase_checker_assertions.sv
`timescale 1ns/1ps
module erase_checker (
    // Clock and reset
    input wire        mclk_i,
    input wire        rst_b_i,
    // Bus answer and erase inputs
    input wire        s_axi_bvalid,
    input wire        erase_run_i,
    input wire        erase_end_i,
    input wire        err_flag_i,
    input wire        suspend_flag_i,
    input wire [7:0]  sector_hit_i,
    input wire [20:0] program_address_pair_i,
    // Status and data outputs
    input wire [7:0]  sector_select_o,
    input wire [63:0] program_data_o,
    input wire [20:0] program_address_o,
    input wire        bank_status_bit_o,
    input wire        bank_erase_failed_o,
    input wire        bank_erase_suspended_o,
    input wire [7:0]  sector_failed_o,
    input wire [7:0]  sector_suspended_o
);
    // One clock domain, so one default clock and reset
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    // Erase activity shows in the bank bit at the next edge
    a_run_bank_set: assert property (erase_run_i |=> bank_status_bit_o)
        else $error("bank bit not set during erase");
    // Every sector the erase touches is flagged next edge
    a_run_sector_set: assert property (erase_run_i |=>
        ((sector_select_o & $past(sector_hit_i)) == $past(sector_hit_i)))
        else $error("sector bits miss erase hits");
    // Clean finish drops the bank bit
    a_clean_end_bank: assert property (erase_end_i && !err_flag_i && !erase_run_i
        |=> !bank_status_bit_o)
        else $error("bank bit kept after clean end");
    // Clean finish drops all sector bits
    a_clean_end_sector: assert property (erase_end_i && !err_flag_i && !erase_run_i
        |=> sector_select_o == 8'h00)
        else $error("sector bits kept after clean end");
    // Error flag turns set bits into failure marks
    a_fail_meaning: assert property ({bank_erase_failed_o, sector_failed_o} ==
        ({bank_status_bit_o, sector_select_o} & {9{err_flag_i}}))
        else $error("failure view wrong");
    // Suspend without error turns them into suspend marks
    a_suspend_flag_meaning: assert property ({bank_erase_suspended_o, sector_suspended_o} ==
        ({bank_status_bit_o, sector_select_o} & {9{!err_flag_i && suspend_flag_i}}))
        else $error("suspend view wrong");
    // Target address passes straight through
    a_addr_pass: assert property (program_address_o == program_address_pair_i)
        else $error("program address differs");
    // Data only moves at the edge that completes a write
    a_data_hold: assert property (!$rose(s_axi_bvalid) |-> $stable(program_data_o))
        else $error("data changed without a write");
endmodule // erase_checker

bind flash_erase_status_data_regs erase_checker u_erase_checker (
    .mclk_i, .rst_b_i, .s_axi_bvalid, .erase_run_i, .erase_end_i, .err_flag_i,
    .suspend_flag_i, .sector_hit_i, .program_address_pair_i, .sector_select_o,
    .program_data_o, .program_address_o, .bank_status_bit_o, .bank_erase_failed_o,
    .bank_erase_suspended_o, .sector_failed_o, .sector_suspended_o
);

//--- flash_erase_status_data_regs_bench.sv
`timescale 1ns/1ps
`include "flash_status_regs.vh"
module flash_erase_status_data_regs_bench;
    // Compare, count, report on mismatch
    `define CHK(nm, got, exp) begin checks_done++; if ((got) !== (exp)) begin fail_count++; \
        $display("[ERR] %s expected %h seen %h", nm, exp, got); end end
    logic        mclk_i, rst_b_i;               // Clock and reset
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        erase_run_i, erase_end_i, err_flag_i, suspend_flag_i;
    logic [7:0]  sector_hit_i, sector_select_o, sector_failed_o, sector_suspended_o;
    logic [20:0] program_address_pair_i, program_address_o;
    logic [63:0] program_data_o;
    logic        bank_status_bit_o, bank_erase_failed_o, bank_erase_suspended_o, irq_o;
    int          fail_count = 0;                // Mismatches
    int          checks_done = 0;               // Comparisons
    logic [31:0] rd;                            // Last read word
    logic [31:0] dreg [4];                      // Data register addresses
    flash_erase_status_data_regs dut (.*);
    // 25 MHz clock
    initial begin
        mclk_i = 1'b0;
        forever #20 mclk_i = ~mclk_i;
    end
    // Verdict and end of run
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Bus write; each channel dropped at the edge it is taken
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        int n = 0;
        logic ta, tw, tb, done;
        done = 1'b0;
        @(posedge mclk_i);
        s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
        while (!done && n < 50) begin
            // Ready lines are settled at the falling edge and hold to the next rising one
            @(negedge mclk_i);
            ta = s_axi_awvalid & s_axi_awready;
            tw = s_axi_wvalid & s_axi_wready;
            tb = s_axi_bvalid;
            if (tb) `CHK("bresp", s_axi_bresp, er)
            @(posedge mclk_i);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (tb) begin s_axi_bready <= 1'b0; done = 1'b1; end
            n++;
        end
        if (!done) begin fail_count++; close_out(); end
    endtask
    // Bus read; data taken at the edge rvalid is sampled
    task automatic rdc(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] er);
        int n = 0;
        logic ta, done;
        done = 1'b0;
        @(posedge mclk_i);
        s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
        while (!done && n < 50) begin
            @(negedge mclk_i);
            ta = s_axi_arvalid & s_axi_arready;
            if (s_axi_rvalid) begin
                done = 1'b1;
                rd = s_axi_rdata;
                `CHK("rresp", s_axi_rresp, er)
                `CHK("rdata", s_axi_rdata, exp)
            end
            @(posedge mclk_i);
            if (ta) s_axi_arvalid <= 1'b0;
            if (done) s_axi_rready <= 1'b0;
            n++;
        end
        if (!done) begin fail_count++; close_out(); end
    endtask
    // Erase input step: drive at the edge, look at the falling edge after
    task automatic er_step(input logic run, input logic fin, input logic e, input logic sp);
        @(posedge mclk_i);
        erase_run_i <= run; erase_end_i <= fin; err_flag_i <= e; suspend_flag_i <= sp;
        @(negedge mclk_i);
    endtask
    // Main sequence
    initial begin
        rst_b_i = 1'b0; s_axi_awvalid = 1'b0; s_axi_wvalid = 1'b0; s_axi_bready = 1'b0;
        s_axi_arvalid = 1'b0; s_axi_rready = 1'b0; s_axi_awaddr = '0; s_axi_wdata = '0;
        s_axi_wstrb = '0; s_axi_araddr = '0; erase_run_i = 1'b0; erase_end_i = 1'b0;
        err_flag_i = 1'b0; suspend_flag_i = 1'b0; sector_hit_i = 8'h00;
        program_address_pair_i = 21'h1a2b3c;
        dreg = '{`BYTE_ADDR(`IDX_PROGRAM_DATA0_LOW), `BYTE_ADDR(`IDX_PROGRAM_DATA0_HIGH),
                 `BYTE_ADDR(`IDX_PROGRAM_DATA1_LOW), `BYTE_ADDR(`IDX_PROGRAM_DATA1_HIGH)};
        repeat (16) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        // Reset values of the register table
        for (int i = 0; i < 4; i++) rdc(dreg[i], 32'h0000ffff, `RESP_OKAY);
        rdc(`BYTE_ADDR(`IDX_BANK_ERASE_STATUS_HIGH), 32'h00000000, `RESP_OKAY);
        `CHK("program_data_o", program_data_o, 64'hffff_ffff_ffff_ffff)
        `CHK("program_address_o", program_address_o, 21'h1a2b3c)
        // Double word load: even word in data 0, odd word in data 1
        for (int i = 0; i < 4; i++) wr(dreg[i], 32'h1234 + 32'h1111 * i, 4'h3, `RESP_OKAY);
        `CHK("program_data_o", program_data_o, 64'h4567_3456_2345_1234)
        // One byte lane only; the other lane keeps its value
        wr(dreg[0], 32'h000000ee, 4'h1, `RESP_OKAY);
        for (int i = 0; i < 4; i++)
            rdc(dreg[i], (i == 0) ? 32'h12ee : 32'h1234 + 32'h1111 * i, `RESP_OKAY);
        // Unmapped word: error answer, no data
        wr(`BYTE_ADDR(24'h080040), 32'h0000aaaa, 4'hf, `RESP_SLVERR);
        rdc(`BYTE_ADDR(24'h080040), 32'h00000000, `RESP_SLVERR);
        // Software chooses sectors
        wr(`BYTE_ADDR(`IDX_SECTOR_SELECT_STATUS_LOW), 32'h000000a5, 4'h3, `RESP_OKAY);
        `CHK("sector_select_o", sector_select_o, 8'ha5)
        wr(`BYTE_ADDR(`IDX_SECTOR_SELECT_STATUS_LOW), 32'h00000000, 4'h3, `RESP_OKAY);
        // Erase running while suspended, then with an error
        sector_hit_i <= 8'h05;
        er_step(1'b1, 1'b0, 1'b0, 1'b1);
        er_step(1'b1, 1'b0, 1'b0, 1'b1);
        `CHK("bank_status_bit_o", bank_status_bit_o, 1'b1)
        `CHK("sector_select_o", sector_select_o, 8'h05)
        `CHK("bank_suspended", bank_erase_suspended_o, 1'b1)
        `CHK("sector_suspended", sector_suspended_o, 8'h05)
        er_step(1'b1, 1'b0, 1'b1, 1'b1);
        `CHK("bank_failed", bank_erase_failed_o, 1'b1)
        `CHK("sector_failed", sector_failed_o, 8'h05)
        `CHK("sector_suspended", sector_suspended_o, 8'h00)
        // Live flags as seen by software: suspend, error, end, run
        rdc(`BYTE_ADDR(`IDX_ERASE_VIEW), 32'h0000000d, `RESP_OKAY);
        // Finish with an error: status is kept
        er_step(1'b0, 1'b1, 1'b1, 1'b0);
        er_step(1'b0, 1'b0, 1'b1, 1'b0);
        `CHK("bank_status_bit_o", bank_status_bit_o, 1'b1)
        rdc(`BYTE_ADDR(`IDX_BANK_ERASE_STATUS_HIGH), 32'h00000100, `RESP_OKAY);
        rdc(`BYTE_ADDR(`IDX_SECTOR_SELECT_STATUS_LOW), 32'h00000005, `RESP_OKAY);
        // Clean finish clears the bank bit and all sector bits
        er_step(1'b0, 1'b1, 1'b0, 1'b0);
        er_step(1'b0, 1'b0, 1'b0, 1'b0);
        `CHK("bank_status_bit_o", bank_status_bit_o, 1'b0)
        `CHK("sector_select_o", sector_select_o, 8'h00)
        // Clean end, failed end and suspend entry all left their event bit
        rdc(`BYTE_ADDR(`IDX_IRQ_STATUS), 32'h00000007, `RESP_OKAY);
        `CHK("clean end event", rd[`IRQ_END_OK], 1'b1)
        `CHK("irq masked", irq_o, 1'b0)
        wr(`BYTE_ADDR(`IDX_IRQ_MASK), 32'h1, 4'hf, `RESP_OKAY);
        @(negedge mclk_i);
        `CHK("irq unmasked", irq_o, 1'b1)
        wr(`BYTE_ADDR(`IDX_IRQ_STATUS), 32'h7, 4'hf, `RESP_OKAY);
        @(negedge mclk_i);
        `CHK("irq cleared", irq_o, 1'b0)
        rdc(`BYTE_ADDR(`IDX_IRQ_STATUS), 32'h0, `RESP_OKAY);
        close_out();
    end
endmodule // flash_erase_status_data_regs_bench
